// ---- logic/fsp_pkg.sv ----
// shared constants for the fused sum-of-products array block
package fsp_pkg;
  // array geometry
  localparam int NUM_IN_PAIRS = 16;
  localparam int NUM_LINES = 2 * NUM_IN_PAIRS;
  localparam int NUM_TERMS = 64;
  localparam int TERMS_PER_GRP = 8;
  localparam int NUM_OUT = 8;
  localparam int NUM_FUSES = NUM_LINES * NUM_TERMS;
  localparam int NUM_DED = 10;
  localparam int NUM_SEC = 2;
  localparam int SEC_SPLIT_TERM = 32;
  // apb map, byte addresses
  localparam logic [11:0] FUSE_BASE = 12'h000;
  localparam logic [11:0] CTRL_OFS = 12'h100;
  localparam logic [11:0] STAT_OFS = 12'h104;
  // field positions
  localparam int CTRL_SEC_LSB = 0;
  localparam int STAT_Q_LSB = 0;
  localparam int STAT_OE_LSB = 8;
  localparam int STAT_PIN_LSB = 16;
  localparam int STAT_READY_BIT = 24;
  // reset values: intact fuses, security fuses intact, registers low
  localparam logic [NUM_LINES-1:0] FUSE_RST = 32'h0000_0000;
  localparam logic [NUM_SEC-1:0] SEC_RST = 2'h0;
  localparam logic [NUM_OUT-1:0] REG_RST = 8'h00;
  // pin synchroniser reset: enable pin idles high, so no false driver enable
  localparam logic [NUM_DED+NUM_OUT+2:0] SYNC_RST = {3'h2, {(NUM_OUT + NUM_DED){1'b0}}};
  // power-up clear interval
  localparam int POWER_UP_CLEAR_NS = 1000;
  localparam int CLK_MHZ = 40;
  localparam int POWER_UP_CLEAR_CYC = (POWER_UP_CLEAR_NS * CLK_MHZ) / 1000;
  typedef enum logic [1:0] {
    FSP_ST_CLEAR = 2'b01,
    FSP_ST_RUN = 2'b10
  } fsp_state_t;
endpackage : fsp_pkg

// ---- logic/fsp_array_if.sv ----
// carrier between the array owner and the and-array evaluator
`timescale 1ns/1ps
interface fsp_array_if;
  import fsp_pkg::*;
  logic [NUM_LINES-1:0] lines;
  logic [NUM_LINES-1:0] blown [NUM_TERMS];
  logic [NUM_TERMS-1:0] term;
  modport array (input lines, input blown, output term);
  modport owner (output lines, output blown, input term);
endinterface : fsp_array_if

// ---- logic/fsp_and_array.sv ----
// programmable and array: one product term per fuse word
`timescale 1ns/1ps
module fsp_and_array
  import fsp_pkg::*;
(
  fsp_array_if.array a
);
  // a blown fuse forces its line to one, so it drops out of the and
  genvar t;
  generate
    for (t = 0; t < NUM_TERMS; t++) begin : g_term
      assign a.term[t] = &(a.blown[t] | a.lines);
    end
  endgenerate
endmodule : fsp_and_array

// ---- logic/fsp_top.sv ----
// fused sum-of-products array device with apb fuse access
//
// Behaviour
// - 16 input pairs cross 64 product terms, two fuses each, 2048 total.
// - eight groups of eight terms; seven feed combinatorial, eight feed registered.
// - intact fuse connects its line to the term; blown fuse removes it.
// - term true only when all connected lines high; both phases keep it low.
// - term with every fuse blown is always true, and so is its function.
// - variants have 0, 4, 6 or 8 registered outputs, rest combinatorial.
// - every output is active low and can be tri-stated.
// - combinatorial output uses seven terms; first term enables its driver.
// - combinatorial pins feed back, except two on the all-combinatorial variant.
// - registered outputs sum eight terms into flops clocked by the clock pin.
// - one active-low enable pin drives all registered outputs together.
// - register state feeds back internally, sequencing while drivers are off.
// - power-up clears every register, so enabled registered outputs read high.
// - toggling an unconnected input leaves every output unchanged.
// - registers load asynchronously from the registered pins in test.
// - two security fuses each block programming and readout of their half.
// - security fuses do not block register preload.
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module fsp_top
  import fsp_pkg::*;
#(
  parameter int NUM_REG = 4
)
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [NUM_DED-1:0] i_ded_in,
  input wire logic i_pin_clk,
  input wire logic i_oe_n,
  input wire logic i_preload,
  input wire logic [NUM_OUT-1:0] i_io_i,
  output logic [NUM_OUT-1:0] o_io_o,
  output logic [NUM_OUT-1:0] o_io_oe
);
  localparam int SYNC_W = NUM_DED + NUM_OUT + 3;
  localparam int CNT_W = $clog2(POWER_UP_CLEAR_CYC + 1);

  // true when output slot k is registered in this variant
  function automatic logic is_reg(input int k);
    return (k >= (NUM_OUT - NUM_REG) / 2) && (k < (NUM_OUT + NUM_REG) / 2);
  endfunction : is_reg

  // true when fuse word idx lies under a blown security fuse
  function automatic logic is_locked(input logic [5:0] idx, input logic [NUM_SEC-1:0] sec);
    return sec[idx >= 6'(SEC_SPLIT_TERM)];
  endfunction : is_locked

  logic [NUM_OUT-1:0] reg_mask;
  always_comb begin
    for (int k = 0; k < NUM_OUT; k++) begin
      reg_mask[k] = is_reg(k);
    end
  end

  // pin synchronisers; only the second stage is read
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic clk_prev_q;
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_q <= SYNC_RST;
      sync2_q <= SYNC_RST;
      clk_prev_q <= 1'b0;
    end else begin
      sync1_q <= {i_preload, i_oe_n, i_pin_clk, i_io_i, i_ded_in};
      sync2_q <= sync1_q;
      clk_prev_q <= sync2_q[NUM_DED + NUM_OUT];
    end
  end

  logic [NUM_DED-1:0] ded_s;
  logic [NUM_OUT-1:0] io_s;
  logic pin_clk_s;
  logic oe_n_s;
  logic preload_s;
  logic clk_rise;
  assign ded_s = sync2_q[NUM_DED-1:0];
  assign io_s = sync2_q[NUM_DED +: NUM_OUT];
  assign pin_clk_s = sync2_q[NUM_DED + NUM_OUT];
  assign oe_n_s = sync2_q[NUM_DED + NUM_OUT + 1];
  assign preload_s = sync2_q[NUM_DED + NUM_OUT + 2];
  assign clk_rise = pin_clk_s && !clk_prev_q;

  // fuse store and security fuses
  logic [NUM_LINES-1:0] blown_q [NUM_TERMS];
  logic [NUM_LINES-1:0] blown_d [NUM_TERMS];
  logic [NUM_SEC-1:0] sec_q;
  logic [NUM_SEC-1:0] sec_d;
  logic [NUM_OUT-1:0] q_q;
  logic [NUM_OUT-1:0] q_d;
  logic [NUM_OUT-1:0] out_q;
  logic [NUM_OUT-1:0] out_d;
  logic [NUM_OUT-1:0] oe_q;
  logic [NUM_OUT-1:0] oe_d;
  fsp_state_t state_q;
  fsp_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;

  // apb decode; zero wait states, access phase always ready
  logic setup;
  logic access;
  logic fuse_hit;
  logic ctrl_hit;
  logic stat_hit;
  logic [5:0] word_idx;
  logic locked;
  assign setup = i_psel && !i_penable;
  assign access = i_psel && i_penable;
  assign fuse_hit = (i_paddr[11:8] == FUSE_BASE[11:8]) && (i_paddr[1:0] == 2'h0);
  assign ctrl_hit = (i_paddr == CTRL_OFS);
  assign stat_hit = (i_paddr == STAT_OFS);
  assign word_idx = i_paddr[7:2];
  assign locked = fuse_hit && is_locked(word_idx, sec_q);
  assign o_pready = access;
  // error on unmapped address or secured fuse word
  assign o_pslverr = access && (!(fuse_hit || ctrl_hit || stat_hit) || locked);
  assign o_prdata = prdata_q;

  // fuse programming and security fuse blowing
  always_comb begin
    blown_d = blown_q;
    sec_d = sec_q;
    if (access && i_pwrite && fuse_hit && !locked) begin
      blown_d[word_idx] = i_pwdata;
    end
    // security fuses only ever blow; a zero write cannot restore them
    if (access && i_pwrite && ctrl_hit) begin
      sec_d = sec_q | i_pwdata[CTRL_SEC_LSB +: NUM_SEC];
    end
  end

  // read data captured in the setup cycle, shown in the access cycle
  always_comb begin
    prdata_d = prdata_q;
    if (setup) begin
      prdata_d = '0;
      if (fuse_hit && !locked) begin
        prdata_d = blown_q[word_idx];
      end else if (ctrl_hit) begin
        prdata_d[CTRL_SEC_LSB +: NUM_SEC] = sec_q;
      end else if (stat_hit) begin
        prdata_d[STAT_Q_LSB +: NUM_OUT] = q_q;
        prdata_d[STAT_OE_LSB +: NUM_OUT] = oe_q;
        prdata_d[STAT_PIN_LSB +: NUM_OUT] = out_q;
        prdata_d[STAT_READY_BIT] = (state_q == FSP_ST_RUN);
      end
    end
  end

  // array input lines: dedicated pins, then one line per output slot, its feedback or a spare dedicated pin
  fsp_array_if arr ();
  logic [NUM_IN_PAIRS-1:0] in_val;
  always_comb begin
    in_val[NUM_OUT-1:0] = ded_s[NUM_OUT-1:0];
    for (int k = 0; k < NUM_OUT; k++) begin
      if (reg_mask[k]) begin
        in_val[NUM_OUT + k] = q_q[k];
      end else if (NUM_REG == 0 && (k == 0 || k == NUM_OUT - 1)) begin
        // outer slots have no feedback; spare dedicated pins take their lines
        in_val[NUM_OUT + k] = (k == 0) ? ded_s[NUM_OUT] : ded_s[NUM_OUT + 1];
      end else begin
        in_val[NUM_OUT + k] = io_s[k];
      end
    end
    for (int i = 0; i < NUM_IN_PAIRS; i++) begin
      arr.lines[2 * i] = in_val[i];
      arr.lines[2 * i + 1] = !in_val[i];
    end
  end
  assign arr.blown = blown_q;

  fsp_and_array u_and_array (
    .a(arr.array)
  );

  // fixed or gates per group
  logic [NUM_OUT-1:0] sum;
  logic [NUM_OUT-1:0] term_en;
  always_comb begin
    for (int k = 0; k < NUM_OUT; k++) begin
      if (reg_mask[k]) begin
        sum[k] = |arr.term[k * TERMS_PER_GRP +: TERMS_PER_GRP];
      end else begin
        sum[k] = |arr.term[k * TERMS_PER_GRP + 1 +: TERMS_PER_GRP - 1];
      end
      term_en[k] = arr.term[k * TERMS_PER_GRP];
    end
  end

  // power-up clear, then clock-pin capture or preload
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    q_d = q_q;
    unique case (state_q)
      FSP_ST_CLEAR: begin
        // clock pin edges are ignored until the clear interval ends
        q_d = REG_RST;
        cnt_d = cnt_q + CNT_W'(1);
        if (cnt_q == CNT_W'(POWER_UP_CLEAR_CYC - 1)) begin
          state_d = FSP_ST_RUN;
        end
      end
      FSP_ST_RUN: begin
        // preload ignores security fuses and the clock
        if (preload_s) begin
          q_d = ~io_s & reg_mask;
        end else if (clk_rise) begin
          q_d = sum & reg_mask;
        end
      end
    endcase
  end

  // pin drivers are registered: one cycle after the array settles
  always_comb begin
    for (int k = 0; k < NUM_OUT; k++) begin
      out_d[k] = reg_mask[k] ? !q_q[k] : !sum[k];
      oe_d[k] = reg_mask[k] ? !oe_n_s : term_en[k];
    end
  end
  assign o_io_o = out_q;
  assign o_io_oe = oe_q;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int t = 0; t < NUM_TERMS; t++) begin
        blown_q[t] <= FUSE_RST;
      end
      sec_q <= SEC_RST;
      q_q <= REG_RST;
      out_q <= '1;
      oe_q <= '0;
      state_q <= FSP_ST_CLEAR;
      cnt_q <= '0;
      prdata_q <= '0;
    end else begin
      blown_q <= blown_d;
      sec_q <= sec_d;
      q_q <= q_d;
      out_q <= out_d;
      oe_q <= oe_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
      prdata_q <= prdata_d;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  property p_clear_hold;
    state_q == FSP_ST_CLEAR |-> q_q == REG_RST && (out_q | ~reg_mask) == '1;
  endproperty
  a_clear_hold: assert property (p_clear_hold) else $error("register not clear at power-up");

  property p_clear_len;
    $rose(state_q == FSP_ST_RUN) |-> $past(cnt_q) == CNT_W'(POWER_UP_CLEAR_CYC - 1);
  endproperty
  a_clear_len: assert property (p_clear_len) else $error("clear interval length wrong");

  property p_preload;
    state_q == FSP_ST_RUN && preload_s |=> q_q == (~$past(io_s) & reg_mask);
  endproperty
  a_preload: assert property (p_preload) else $error("preload did not copy pins");

  property p_preload_secured;
    state_q == FSP_ST_RUN && preload_s && sec_q == '1 |=> q_q == (~$past(io_s) & reg_mask);
  endproperty
  a_preload_secured: assert property (p_preload_secured) else $error("preload blocked");

  property p_capture;
    state_q == FSP_ST_RUN && !preload_s && clk_rise |=> q_q == ($past(sum) & reg_mask);
  endproperty
  a_capture: assert property (p_capture) else $error("register missed clock edge");

  property p_hold;
    state_q == FSP_ST_RUN && !preload_s && !clk_rise |=> q_q == $past(q_q);
  endproperty
  a_hold: assert property (p_hold) else $error("register changed without edge");

  property p_reg_oe;
    ##1 ((oe_q & reg_mask) == ({NUM_OUT{!$past(oe_n_s)}} & reg_mask));
  endproperty
  a_reg_oe: assert property (p_reg_oe) else $error("registered enable wrong");

  property p_comb_pin;
    ##1 ((oe_q & ~reg_mask) == ($past(term_en) & ~reg_mask))
      && ((out_q & ~reg_mask) == (~$past(sum) & ~reg_mask));
  endproperty
  a_comb_pin: assert property (p_comb_pin) else $error("combinatorial pin wrong");

  property p_sec_write;
    access && i_pwrite && fuse_hit && is_locked(word_idx, sec_q)
      |=> blown_q[$past(word_idx)] == $past(blown_q[word_idx]);
  endproperty
  a_sec_write: assert property (p_sec_write) else $error("secured fuse word written");

  property p_sec_read;
    setup && fuse_hit && is_locked(word_idx, sec_q) |=> o_prdata == 32'h0000_0000;
  endproperty
  a_sec_read: assert property (p_sec_read) else $error("secured fuse word read out");

  property p_all_blown;
    blown_q[0] == '1 |-> arr.term[0];
  endproperty
  a_all_blown: assert property (p_all_blown) else $error("all-blown term not true");
endmodule : fsp_top

// ---- testbench/fsp_board_model.sv ----
// board and tester model: pin clock, output enable, preload strobe, pin levels
`timescale 1ns/1ps
module fsp_board_model (
  input wire logic i_sys_clk,
  input wire logic [7:0] i_io_o,
  input wire logic [7:0] i_io_oe,
  output logic o_pin_clk,
  output logic o_oe_n,
  output logic o_preload,
  output logic [7:0] o_pin
);
  logic [7:0] drv_en;
  logic [7:0] drv_val;
  logic flip = 1'b0;

  // clock pin held still from power-up, pulsed only after the clear interval
  initial begin
    o_pin_clk = 1'b0;
    o_oe_n = 1'b1;
    o_preload = 1'b0;
    drv_en = 8'h00;
    drv_val = 8'h00;
  end

  // no pull on the pins, so an undriven pin shows a pattern that moves every cycle
  always @(posedge i_sys_clk) begin
    flip <= ~flip;
  end

  // pin level: device driver first, then tester, else floating
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      o_pin[i] = i_io_oe[i] ? i_io_o[i] : (drv_en[i] ? drv_val[i] : flip ^ i[0]);
    end
  end

  task automatic hold(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask : hold

  // clock pin kept high and low long enough for the synchroniser
  task automatic pulse_clk();
    @(posedge i_sys_clk);
    o_pin_clk <= 1'b1;
    hold(4);
    o_pin_clk <= 1'b0;
    hold(4);
  endtask : pulse_clk

  task automatic set_oe(input logic v);
    @(posedge i_sys_clk);
    o_oe_n <= v;
  endtask : set_oe

  // preload: disable, drive pins, strobe, release; 6 cycles exceed 100 ns per step
  task automatic preload(input logic [7:0] pins, input logic [7:0] mask);
    @(posedge i_sys_clk);
    o_oe_n <= 1'b1;
    hold(6);
    drv_val <= pins;
    drv_en <= mask;
    hold(6);
    o_preload <= 1'b1;
    hold(6);
    o_preload <= 1'b0;
    hold(6);
    drv_en <= 8'h00;
    hold(6);
  endtask : preload
endmodule : fsp_board_model

// ---- testbench/test_fsp_top.sv ----
// self-checking testbench for the fused sum-of-products array block
`timescale 1ns/1ps
module test_fsp_top;
  import fsp_pkg::*;
  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, pin_clk, oe_n, preload;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [NUM_DED-1:0] ded_in;
  logic [7:0] pins, io_o, io_oe;
  int num_errors = 0;
  int tests_run = 0;

  fsp_top #(.NUM_REG(4)) fsp_top_inst (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_ded_in(ded_in), .i_pin_clk(pin_clk),
    .i_oe_n(oe_n), .i_preload(preload), .i_io_i(pins), .o_io_o(io_o), .o_io_oe(io_oe)
  );

  fsp_board_model fsp_board_model_inst (
    .i_sys_clk(sys_clk), .i_io_o(io_o), .i_io_oe(io_oe), .o_pin_clk(pin_clk),
    .o_oe_n(oe_n), .o_preload(preload), .o_pin(pins)
  );

  // 40 MHz
  always #12.5 sys_clk = ~sys_clk;

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  task automatic check_bit(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wait_cyc

  // one apb transfer; read data lands in rdata, error flag compared
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic err);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
      n++;
      if (n > 50) begin
        num_errors++;
        break;
      end
    end
    rdata = prdata;
    check_bit("slave error", err, pslverr);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus

  task automatic give_verdict();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  // watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    give_verdict();
  end

  // main sequence
  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ded_in = '0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    bus(1'b0, STAT_OFS, 32'h0, 1'b0);
    check_word("status in clear", 32'h00FF0000, rdata);
    wait_cyc(POWER_UP_CLEAR_CYC);
    bus(1'b0, STAT_OFS, 32'h0, 1'b0);
    check_word("status after clear", 32'h01FF0000, rdata);
    bus(1'b0, 12'h200, 32'h0, 1'b1);
    check_word("unmapped read", 32'h0, rdata);
    bus(1'b1, STAT_OFS, 32'hFFFFFFFF, 1'b0);
    bus(1'b0, STAT_OFS, 32'h0, 1'b0);
    check_word("status after write", 32'h01FF0000, rdata);
    // slot 0: enable term fully blown, term 1 follows input 0
    bus(1'b1, FUSE_BASE, 32'hFFFFFFFF, 1'b0);
    bus(1'b1, FUSE_BASE + 12'h004, 32'hFFFFFFFE, 1'b0);
    for (int v = 0; v < 2; v++) begin
      ded_in[0] <= v[0];
      wait_cyc(6);
      check_bit("comb enable", 1'b1, io_oe[0]);
      check_bit("comb out", ~v[0], io_o[0]);
    end
    ded_in[5] <= 1'b1;
    wait_cyc(6);
    check_bit("unused input", 1'b0, io_o[0]);
    bus(1'b1, FUSE_BASE + 12'h004, 32'hFFFFFFFC, 1'b0);
    wait_cyc(6);
    check_bit("both phases", 1'b1, io_o[0]);
    bus(1'b1, FUSE_BASE + 12'h008, 32'hFFFFFFFF, 1'b0);
    wait_cyc(6);
    check_bit("all blown term", 1'b0, io_o[0]);
    // slot 2 register toggles through its complement feedback
    bus(1'b1, FUSE_BASE + 12'h040, 32'hFFDFFFFF, 1'b0);
    for (int k = 0; k < 2; k++) begin
      fsp_board_model_inst.pulse_clk();
      bus(1'b0, STAT_OFS, 32'h0, 1'b0);
      check_word("q while disabled", (k == 0) ? 32'h0104 : 32'h0100, rdata & 32'hFFFF);
    end
    fsp_board_model_inst.set_oe(1'b0);
    wait_cyc(6);
    check_word("reg enables", 32'h3D, {24'h0, io_oe});
    check_bit("reg pin q low", 1'b1, io_o[2]);
    fsp_board_model_inst.pulse_clk();
    wait_cyc(3);
    check_bit("reg pin q high", 1'b0, io_o[2]);
    // security fuses block fuse access but not preload
    bus(1'b1, CTRL_OFS, 32'h3, 1'b0);
    bus(1'b0, CTRL_OFS, 32'h0, 1'b0);
    check_word("security", 32'h3, rdata & 32'h3);
    bus(1'b1, FUSE_BASE, 32'h0, 1'b1);
    bus(1'b0, FUSE_BASE + 12'h080, 32'h0, 1'b1);
    check_word("secured read", 32'h0, rdata);
    check_bit("blocked write", 1'b1, io_oe[0]);
    fsp_board_model_inst.preload(8'h28, 8'h3C);
    bus(1'b0, STAT_OFS, 32'h0, 1'b0);
    check_word("preloaded q", 32'h14, rdata & 32'hFF);
    fsp_board_model_inst.set_oe(1'b0);
    wait_cyc(6);
    check_word("preloaded pins", 32'h28, {24'h0, io_o & 8'h3C});
    give_verdict();
  end
endmodule : test_fsp_top
